/* File: inc/sxdac_pkg.sv */
// Shared constants and types for the six-channel converter update block
package sxdac_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NUM_CH   = 6;
    localparam int NUM_PAIR = 3;
    localparam int CODE_W   = 12;
    localparam int ADDR_W   = 4;

    // ------------------------------------------------------------
    // I/O offsets from the base address
    // ------------------------------------------------------------
    localparam logic [3:0] OFF_CH0_LOW  = 4'h0;
    localparam logic [3:0] OFF_CH0_HIGH = 4'h1;
    localparam logic [3:0] OFF_CH_LAST  = 4'hb;
    localparam logic [3:0] OFF_PORTA    = 4'hc;
    localparam logic [3:0] OFF_PORTB    = 4'hd;
    localparam logic [3:0] OFF_PORTC    = 4'he;
    localparam logic [3:0] OFF_CTRL     = 4'hf;

    // ------------------------------------------------------------
    // Digital I/O control word fields
    // ------------------------------------------------------------
    localparam int CTRL_MODE_SET = 7;
    localparam int CTRL_A_IN     = 4;
    localparam int CTRL_CU_IN    = 3;
    localparam int CTRL_B_IN     = 1;
    localparam int CTRL_CL_IN    = 0;
    localparam int BSR_SEL_LSB   = 1;
    localparam int BSR_VAL       = 0;
    localparam logic [7:0] CTRL_RESET  = 8'h9b;
    localparam logic [7:0] PORT_RESET  = 8'h00;
    localparam logic [7:0] RDATA_IDLE  = 8'h00;

    // ------------------------------------------------------------
    // Port C sharing with the update logic
    // ------------------------------------------------------------
    localparam int PC_TRIG_LSB = 4;
    localparam int PC_GATE_LSB = 0;
    localparam int HIGH_NIB_W  = 4;

    // ------------------------------------------------------------
    // Host I/O cycle, one cycle per access
    // ------------------------------------------------------------
    typedef struct packed {
        logic             sel;
        logic             wr;
        logic             rd;
        logic [ADDR_W-1:0] addr;
        logic [7:0]       wdata;
    } sxdac_io_req_t;

endpackage : sxdac_pkg

/* File: src/sxdac_pair_update.sv */
// Update-event selection for one pair of converter channels
`timescale 1ns/1ps
`default_nettype none

module sxdac_pair_update (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // Update causes
    input  wire logic [1:0] hi_wr,
    input  wire logic       sim_rd,
    input  wire logic       soft_sel,
    input  wire logic       ext_sel,
    input  wire logic       ext_line,
    input  wire logic       ext_gate,
    // Output latch load strobes
    output logic [1:0]      load
);

    logic ext_prev_r;

    // Idle level high so that reset release never looks like an edge
    wire  ext_fall_w  = ext_prev_r & ~ext_line & ext_gate;
    wire  immediate_w = ~soft_sel & ~ext_sel;

    // Each pair picks its own cause, so modes mix freely
    assign load = ({2{immediate_w}} & hi_wr)
                | {2{soft_sel & sim_rd}}
                | {2{ext_sel & ext_fall_w}};

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ext_prev_r <= 1'b1;
        end else begin
            ext_prev_r <= ext_line;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_imm_load;
        @(posedge sys_clk) disable iff (!nrst)
        (!soft_sel && !ext_sel) |-> (load == hi_wr);
    endproperty
    a_imm_load: assert property (p_imm_load)
        else $error("immediate pair load differs from high write");

    property p_soft_load;
        @(posedge sys_clk) disable iff (!nrst)
        (soft_sel && sim_rd) |-> (load == 2'b11);
    endproperty
    a_soft_load: assert property (p_soft_load)
        else $error("simultaneous read did not load both channels");

    property p_ext_load;
        @(posedge sys_clk) disable iff (!nrst)
        (ext_sel && ext_gate && $fell(ext_line)) |-> (load == 2'b11);
    endproperty
    a_ext_load: assert property (p_ext_load)
        else $error("external falling edge did not load the pair");

    property p_ext_wait;
        @(posedge sys_clk) disable iff (!nrst)
        (ext_sel && !soft_sel && !$fell(ext_line)) |-> (load == 2'b00);
    endproperty
    a_ext_wait: assert property (p_ext_wait)
        else $error("external pair loaded without an edge");

    c_ext_load: cover property (@(posedge sys_clk) disable iff (!nrst)
        ext_sel && (load == 2'b11));

endmodule : sxdac_pair_update

`default_nettype wire

/* File: src/sxdac_top.sv */
// Six-channel 12-bit converter load/update control with digital I/O ports
//
// What this block does
// - Each channel takes an unsigned 12-bit code, 0 to 4095.
// - With neither soft nor external selection, high byte write updates that output.
// - Soft mode: any read of offsets 0..11 updates selected pairs.
// - External mode: pair updates on falling edge of its update input.
// - Each pair chooses its own mode; modes may be mixed.
// - Pair update inputs are port C bits 4, 5 and 6.
// - Port C bits 0, 1 and 2 gate the pair update inputs.
// - Gate line enables trigger; from outside or from port C output.
// - Code right-justified: low byte 8 LSBs, high nibble 4 MSBs.
// - Double buffered: input latch, output latch loaded only on update.
// - 24 digital I/O lines as ports A, B, C lower and C upper.
// - Sixteen offsets: twelve channel bytes, three digital I/O ports and control.
`timescale 1ns/1ps
`default_nettype none

module sxdac_top #(
    parameter int NCH   = sxdac_pkg::NUM_CH,
    parameter int NPAIR = sxdac_pkg::NUM_PAIR
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  nrst,
    // Host I/O cycle and read data
    input  wire sxdac_pkg::sxdac_io_req_t io_req,
    output logic [7:0]                 io_rdata,
    // Update mode switches, one bit per pair
    input  wire logic [NPAIR-1:0]      soft_simul_pair_select,
    input  wire logic [NPAIR-1:0]      ext_trigger_pair_select,
    // Converter output latches
    output logic [NCH-1:0][11:0]       analog_output_channel,
    // Digital port A
    input  wire logic [7:0]            porta_in,
    output logic [7:0]                 porta_out,
    output logic [7:0]                 porta_oe,
    // Digital port B
    input  wire logic [7:0]            portb_in,
    output logic [7:0]                 portb_out,
    output logic [7:0]                 portb_oe,
    // Digital port C, shared with the update lines
    input  wire logic [7:0]            portc_in,
    output logic [7:0]                 portc_out,
    output logic [7:0]                 portc_oe
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [NCH-1:0][7:0]  lo_r;
    logic [NCH-1:0][3:0]  hi_r;
    logic [NCH-1:0][11:0] code_r;
    logic [7:0]           ctrl_r;
    logic [7:0]           pa_r;
    logic [7:0]           pb_r;
    logic [7:0]           pc_r;
    logic [7:0]           pa_oe_r;
    logic [7:0]           pb_oe_r;
    logic [7:0]           pc_oe_r;
    logic [7:0]           rdata_r;

    logic [NCH-1:0]       lo_wr_w;
    logic [NCH-1:0]       hi_wr_w;
    logic [NCH-1:0]       load_w;
    logic [NCH-1:0][7:0]  lo_nxt;
    logic [NCH-1:0][3:0]  hi_nxt;
    logic [NPAIR-1:0]     gate_w;
    logic [NPAIR-1:0]     trig_w;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire wr_w     = io_req.sel & io_req.wr;
    wire rd_w     = io_req.sel & io_req.rd;
    wire ch_adr_w = (io_req.addr <= sxdac_pkg::OFF_CH_LAST);
    wire sim_rd_w = rd_w & ch_adr_w;
    wire wr_pa_w  = wr_w & (io_req.addr == sxdac_pkg::OFF_PORTA);
    wire wr_pb_w  = wr_w & (io_req.addr == sxdac_pkg::OFF_PORTB);
    wire wr_pc_w  = wr_w & (io_req.addr == sxdac_pkg::OFF_PORTC);
    wire wr_ct_w  = wr_w & (io_req.addr == sxdac_pkg::OFF_CTRL);
    wire mode_w   = wr_ct_w & io_req.wdata[sxdac_pkg::CTRL_MODE_SET];
    wire bsr_w    = wr_ct_w & ~io_req.wdata[sxdac_pkg::CTRL_MODE_SET];
    wire [2:0] bsr_bit_w = io_req.wdata[sxdac_pkg::BSR_SEL_LSB +: 3];

    // Control word as it stands after this cycle; direction flops follow it
    wire [7:0] ctrl_nxt = mode_w ? io_req.wdata : ctrl_r;
    wire a_in_w  = ctrl_nxt[sxdac_pkg::CTRL_A_IN];
    wire b_in_w  = ctrl_nxt[sxdac_pkg::CTRL_B_IN];
    wire cu_in_w = ctrl_nxt[sxdac_pkg::CTRL_CU_IN];
    wire cl_in_w = ctrl_nxt[sxdac_pkg::CTRL_CL_IN];

    // ------------------------------------------------------------
    // Input latches: low byte and high nibble, right-justified
    // ------------------------------------------------------------
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        assign lo_wr_w[g] = wr_w & (io_req.addr == 4'(2 * g));
        assign hi_wr_w[g] = wr_w & (io_req.addr == 4'(2 * g + 1));
        assign lo_nxt[g]  = lo_wr_w[g] ? io_req.wdata : lo_r[g];
        assign hi_nxt[g]  = hi_wr_w[g] ? io_req.wdata[3:0] : hi_r[g];
    end

    // ------------------------------------------------------------
    // Pair update selection
    // ------------------------------------------------------------
    // Gate comes from the pin when C lower is input, else our own latch
    for (genvar p = 0; p < NPAIR; p++) begin : g_pair
        assign trig_w[p] = portc_in[sxdac_pkg::PC_TRIG_LSB + p];
        assign gate_w[p] = ctrl_r[sxdac_pkg::CTRL_CL_IN]
                         ? portc_in[sxdac_pkg::PC_GATE_LSB + p]
                         : pc_r[sxdac_pkg::PC_GATE_LSB + p];

        sxdac_pair_update u_pair (
            .sys_clk  (sys_clk),
            .nrst     (nrst),
            .hi_wr    (hi_wr_w[2*p +: 2]),
            .sim_rd   (sim_rd_w),
            .soft_sel (soft_simul_pair_select[p]),
            .ext_sel  (ext_trigger_pair_select[p]),
            .ext_line (trig_w[p]),
            .ext_gate (gate_w[p]),
            .load     (load_w[2*p +: 2])
        );
    end

    // ------------------------------------------------------------
    // Read mux; channel offsets read as idle, control reads as idle
    // ------------------------------------------------------------
    wire [7:0] pa_rd_w = ctrl_r[sxdac_pkg::CTRL_A_IN] ? porta_in : pa_r;
    wire [7:0] pb_rd_w = ctrl_r[sxdac_pkg::CTRL_B_IN] ? portb_in : pb_r;
    wire [7:0] pc_rd_w = {
        ctrl_r[sxdac_pkg::CTRL_CU_IN] ? portc_in[7:4] : pc_r[7:4],
        ctrl_r[sxdac_pkg::CTRL_CL_IN] ? portc_in[3:0] : pc_r[3:0]};
    wire [7:0] rd_mux_w =
        (io_req.addr == sxdac_pkg::OFF_PORTA) ? pa_rd_w :
        (io_req.addr == sxdac_pkg::OFF_PORTB) ? pb_rd_w :
        (io_req.addr == sxdac_pkg::OFF_PORTC) ? pc_rd_w :
        sxdac_pkg::RDATA_IDLE;

    // ------------------------------------------------------------
    // Converter latches
    // ------------------------------------------------------------
    // Output latch takes the value written this same cycle, so a high
    // byte write in immediate mode lands without a one-cycle lag
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            lo_r   <= '0;
            hi_r   <= '0;
            code_r <= '0;
        end else begin
            lo_r <= lo_nxt;
            hi_r <= hi_nxt;
            for (int i = 0; i < NCH; i++) begin
                if (load_w[i]) begin
                    code_r[i] <= {hi_nxt[i], lo_nxt[i]};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Digital I/O, basic input/output operation
    // ------------------------------------------------------------
    // Mode set clears all output latches, as the usual parallel
    // interface does; handshake modes are not modelled
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= sxdac_pkg::CTRL_RESET;
            pa_r   <= sxdac_pkg::PORT_RESET;
            pb_r   <= sxdac_pkg::PORT_RESET;
            pc_r   <= sxdac_pkg::PORT_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
            if (mode_w) begin
                pa_r <= sxdac_pkg::PORT_RESET;
                pb_r <= sxdac_pkg::PORT_RESET;
                pc_r <= sxdac_pkg::PORT_RESET;
            end else begin
                if (wr_pa_w) pa_r <= io_req.wdata;
                if (wr_pb_w) pb_r <= io_req.wdata;
                if (wr_pc_w) pc_r <= io_req.wdata;
                if (bsr_w) pc_r[bsr_bit_w] <= io_req.wdata[sxdac_pkg::BSR_VAL];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pa_oe_r <= 8'h00;
            pb_oe_r <= 8'h00;
            pc_oe_r <= 8'h00;
            rdata_r <= sxdac_pkg::RDATA_IDLE;
        end else begin
            pa_oe_r <= {8{~a_in_w}};
            pb_oe_r <= {8{~b_in_w}};
            pc_oe_r <= {{4{~cu_in_w}}, {4{~cl_in_w}}};
            if (rd_w) rdata_r <= rd_mux_w;
        end
    end

    assign analog_output_channel = code_r;
    assign io_rdata  = rdata_r;
    assign porta_out = pa_r;
    assign portb_out = pb_r;
    assign portc_out = pc_r;
    assign porta_oe  = pa_oe_r;
    assign portb_oe  = pb_oe_r;
    assign portc_oe  = pc_oe_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_out_on_load;
        @(posedge sys_clk) disable iff (!nrst)
        (code_r != $past(code_r)) |-> $past(|load_w);
    endproperty
    a_out_on_load: assert property (p_out_on_load)
        else $error("output latch changed without an update event");

    property p_low_hold;
        @(posedge sys_clk) disable iff (!nrst)
        (lo_wr_w[0] && !load_w[0]) |=> (code_r[0] == $past(code_r[0]));
    endproperty
    a_low_hold: assert property (p_low_hold)
        else $error("low byte write changed channel zero output");

    property p_high_imm;
        @(posedge sys_clk) disable iff (!nrst)
        (hi_wr_w[0] && !soft_simul_pair_select[0]
         && !ext_trigger_pair_select[0])
        |=> (code_r[0] == {$past(io_req.wdata[3:0]), lo_r[0]});
    endproperty
    a_high_imm: assert property (p_high_imm)
        else $error("high byte write did not update channel zero");

    property p_soft_rd;
        @(posedge sys_clk) disable iff (!nrst)
        (sim_rd_w && soft_simul_pair_select[2])
        |=> (code_r[5] == {hi_r[5], lo_r[5]});
    endproperty
    a_soft_rd: assert property (p_soft_rd)
        else $error("simultaneous read missed channel five");

    property p_ctrl_rd;
        @(posedge sys_clk) disable iff (!nrst)
        (rd_w && io_req.addr == sxdac_pkg::OFF_CTRL)
        |=> (io_rdata == sxdac_pkg::RDATA_IDLE);
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd)
        else $error("control offset read returned data");

    property p_dir;
        @(posedge sys_clk) disable iff (!nrst)
        porta_oe == {8{~ctrl_r[sxdac_pkg::CTRL_A_IN]}};
    endproperty
    a_dir: assert property (p_dir)
        else $error("port A enable disagrees with control word");

    c_imm: cover property (@(posedge sys_clk) disable iff (!nrst)
        hi_wr_w[0] ##1 (code_r[0] != $past(code_r[0])));
    c_soft: cover property (@(posedge sys_clk) disable iff (!nrst)
        sim_rd_w && |soft_simul_pair_select);
    c_mix: cover property (@(posedge sys_clk) disable iff (!nrst)
        soft_simul_pair_select[0] && ext_trigger_pair_select[1]
        && !soft_simul_pair_select[2] && !ext_trigger_pair_select[2]);

endmodule : sxdac_top

`default_nettype wire

/* File: verification/six_channel_dac_update_control_bench.sv */
// Self-checking bench for the six-channel converter update block
`timescale 1ns/1ps
`default_nettype none

module six_channel_dac_update_control_bench;
    sxdac_pkg::sxdac_io_req_t io_req;
    logic                     sys_clk;
    logic                     nrst;
    logic [7:0]               io_rdata, porta_in, portb_in, portc_in;
    logic [2:0]               soft_sel, ext_sel;
    logic [5:0][11:0]         aout;
    logic [7:0]               pa_out, pa_oe, pb_out, pb_oe, pc_out, pc_oe;
    int                       bad_count, samples_checked;
    int                       m_lo[6], m_hi[6], m_out[6];
    int                       exp_rd_q[$];

    initial sys_clk = 1'b0;
    always #2.5 sys_clk = ~sys_clk;

    sxdac_top uut (.sys_clk(sys_clk), .nrst(nrst), .io_req(io_req),
        .io_rdata(io_rdata), .soft_simul_pair_select(soft_sel),
        .ext_trigger_pair_select(ext_sel), .analog_output_channel(aout),
        .porta_in(porta_in), .porta_out(pa_out), .porta_oe(pa_oe),
        .portb_in(portb_in), .portb_out(pb_out), .portb_oe(pb_oe),
        .portc_in(portc_in), .portc_out(pc_out), .portc_oe(pc_oe));

    sxdac_host_model host (.sys_clk(sys_clk), .io_req(io_req),
        .io_rdata(io_rdata));

    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    function automatic void m_load(input int p);
        for (int c = 2 * p; c < 2 * p + 2; c++) begin
            m_out[c] = m_hi[c] * 256 + m_lo[c];
        end
    endfunction : m_load

    function automatic void m_write(input int a, input int d);
        int c;
        c = a / 2;
        if (a % 2 == 0) begin
            m_lo[c] = d;
        end else begin
            m_hi[c] = d % 16;
            if (!soft_sel[c / 2] && !ext_sel[c / 2]) begin
                m_out[c] = m_hi[c] * 256 + m_lo[c];
            end
        end
    endfunction : m_write

    // ------------------------------------------------------------
    // Compares
    // ------------------------------------------------------------
    task automatic cmp_code(input int ch, input logic [11:0] exp);
        samples_checked++;
        if (aout[ch] !== exp) begin
            bad_count++;
            $display("BAD code %0d exp %h got %h", ch, exp, aout[ch]);
        end
    endtask : cmp_code

    task automatic cmp_byte(input string what, input logic [7:0] exp,
                            input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : cmp_byte

    task automatic check_codes();
        #1;
        for (int c = 0; c < 6; c++) cmp_code(c, 12'(m_out[c]));
    endtask : check_codes

    // ------------------------------------------------------------
    // Stimulus helpers
    // ------------------------------------------------------------
    task automatic put_code(input int ch, input int n, input logic [7:0] pad);
        host.write_low(ch, n);
        m_write(2 * ch, n % 256);
        check_codes();
        host.write_high(ch, n, pad);
        m_write(2 * ch + 1, int'(pad) + n / 256);
        check_codes();
    endtask : put_code

    task automatic do_read(input int a);
        logic [7:0] got;
        host.io_read(4'(a), got);
        if (a < 12) begin
            exp_rd_q.push_back(0);
            for (int p = 0; p < 3; p++) if (soft_sel[p]) m_load(p);
        end else if (a == 15) begin
            exp_rd_q.push_back(0);
        end else begin
            exp_rd_q.push_back(int'(porta_in));
        end
        cmp_byte("read data", 8'(exp_rd_q.pop_front()), got);
    endtask : do_read

    // Falling edge on the pair's update line, each level held four clocks
    task automatic ext_pulse(input int p, input bit gate);
        @(posedge sys_clk) portc_in[4 + p] <= 1'b1;
        repeat (4) @(posedge sys_clk);
        portc_in[4 + p] <= 1'b0;
        repeat (4) @(posedge sys_clk);
        if (gate && ext_sel[p]) m_load(p);
    endtask : ext_pulse

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        #100000;
        bad_count++;
        finish_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        soft_sel = 3'h0;
        ext_sel = 3'h0;
        porta_in = 8'h00;
        portb_in = 8'h00;
        // Update lines idle high, the edge detector's reset level
        portc_in = 8'h70;
        bad_count = 0;
        samples_checked = 0;
        for (int c = 0; c < 6; c++) begin
            m_lo[c] = 0;
            m_hi[c] = 0;
            m_out[c] = 0;
        end
        void'($urandom(18));
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        porta_in <= 8'($urandom);
        portb_in <= 8'($urandom);
        check_codes();
        cmp_byte("port a oe", 8'h00, pa_oe);
        cmp_byte("port c oe", 8'h00, pc_oe);
        cmp_byte("port b oe", 8'h00, pb_oe);
        cmp_byte("port a out", 8'h00, pa_out);
        cmp_byte("port b out", 8'h00, pb_out);
        // Immediate mode, boundary codes at both ends
        for (int c = 0; c < 6; c++) begin
            put_code(c, (c == 0) ? 0 : (c == 5) ? 4095 : $urandom_range(4095),
                     (c == 5) ? 8'hf0 : 8'h00);
        end
        // Pair 0 immediate, pair 1 software, pair 2 external
        @(posedge sys_clk);
        soft_sel <= 3'h2;
        ext_sel <= 3'h4;
        for (int c = 0; c < 6; c++) begin
            put_code(c, $urandom_range(4095), 8'h00);
        end
        do_read(12);
        do_read(15);
        check_codes();
        do_read($urandom_range(11));
        check_codes();
        ext_pulse(2, 1'b0);
        check_codes();
        @(posedge sys_clk) portc_in[2] <= 1'b1;
        ext_pulse(2, 1'b1);
        check_codes();
        // Gate driven from port C lower as output
        put_code(4, $urandom_range(4095), 8'h00);
        put_code(5, $urandom_range(4095), 8'h00);
        @(posedge sys_clk) portc_in[2] <= 1'b0;
        host.io_write(sxdac_pkg::OFF_CTRL, 8'h9a);
        host.io_write(sxdac_pkg::OFF_CTRL, 8'h05);
        #1;
        cmp_byte("port c oe", 8'h0f, pc_oe);
        cmp_byte("port c out", 8'h04, pc_out);
        ext_pulse(2, 1'b1);
        check_codes();
        host.io_write(sxdac_pkg::OFF_PORTB, 8'h3c);
        #1;
        cmp_byte("port b out", 8'h3c, pb_out);
        // Pair 2 in both soft and external mode, pair 1 stays soft
        @(posedge sys_clk) soft_sel <= 3'h6;
        put_code(5, $urandom_range(4095), 8'h00);
        do_read($urandom_range(11));
        check_codes();
        finish_test();
    end
endmodule : six_channel_dac_update_control_bench
`default_nettype wire

/* File: verification/sxdac_host_model.sv */
// Host processor model issuing one I/O cycle per access
`timescale 1ns/1ps
`default_nettype none

module sxdac_host_model (
    // Clock
    input  wire logic                    sys_clk,
    // Host I/O cycle
    output var sxdac_pkg::sxdac_io_req_t io_req,
    input  wire logic [7:0]              io_rdata
);
    initial begin
        io_req = '0;
    end

    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // Released lines show the inverse, so a stale value never matches
    task automatic drive(input logic w, input logic r,
                         input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        io_req <= '{sel: 1'b1, wr: w, rd: r, addr: a, wdata: d};
        @(posedge sys_clk);
        io_req <= '{sel: 1'b0, wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : drive

    task automatic io_write(input logic [3:0] a, input logic [7:0] d);
        drive(1'b1, 1'b0, a, d);
    endtask : io_write

    task automatic io_read(input logic [3:0] a, output logic [7:0] d);
        drive(1'b0, 1'b1, a, ~io_req.wdata);
        @(posedge sys_clk);
        d = io_rdata;
    endtask : io_read

    // ------------------------------------------------------------
    // Code split, low byte first
    // ------------------------------------------------------------
    task automatic write_low(input int ch, input int n);
        io_write(4'(2 * ch), 8'(n % 256));
    endtask : write_low

    // Pad sets the don't-care upper bits of the high byte
    task automatic write_high(input int ch, input int n,
                              input logic [7:0] pad);
        io_write(4'(2 * ch + 1), pad | 8'(n / 256));
    endtask : write_high
endmodule : sxdac_host_model
`default_nettype wire
